// ==== fd_cfg_if.sv ====
// Purpose: Carries thresholds, dwell and detector state between modules
// Assumes: All signals on the sample clock
// Notes: cfg side drives settings, det side drives results
interface fd_cfg_if;
	logic [12:0] upper;
	logic [12:0] lower;
	logic [15:0] dwell;
	logic [12:0] magnitude;
	logic flag;
	modport cfg (output upper, output lower, output dwell, input magnitude, input flag);
	modport det (input upper, input lower, input dwell, output magnitude, output flag);
endinterface

// ==== fd_hysteresis.sv ====
// Purpose: Magnitude, threshold compare and dwell hysteresis
// Assumes: Two's complement samples, one per clock
// Notes: Flag follows the sample by two clocks
module fd_hysteresis (
	input wire logic clock, // Sample clock
	input wire logic srst, // Synchronous reset
	input wire logic [13:0] sample_in, // Converter output sample
	fd_cfg_if.det cfg // Settings in, magnitude and flag out
);
	logic [13:0] neg_w;
	logic [13:0] abs_w;
	logic [12:0] mag_w;
	logic [12:0] mag_ff;
	logic flag_ff;
	logic [15:0] cnt_ff;
	logic above_w;
	logic below_w;
	logic dwell_done_w;
	logic nxt_flag;
	logic [15:0] nxt_cnt;

	// Most negative code would overflow, so it saturates
	assign neg_w = 14'(~sample_in + 14'h0001);
	assign abs_w = sample_in[13] ? neg_w : sample_in;
	assign mag_w = abs_w[13] ? overrange_pkg::MAG_SAT : abs_w[12:0];

	assign above_w = mag_ff > cfg.upper;
	assign below_w = mag_ff < cfg.lower;
	assign dwell_done_w = cnt_ff >= cfg.dwell;
	// Upper crossing wins over any clear
	assign nxt_flag = above_w ? 1'b1 :
		(flag_ff && below_w && dwell_done_w) ? 1'b0 : flag_ff;
	// Any sample at or above the lower level restarts the dwell
	assign nxt_cnt = (flag_ff && below_w && !above_w) ?
		((cnt_ff == overrange_pkg::DWELL_SAT) ? cnt_ff : 16'(cnt_ff + 16'h0001)) : 16'h0000;

	always_ff @(posedge clock) begin
		if (srst) begin
			mag_ff <= '0;
			flag_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			mag_ff <= mag_w;
			flag_ff <= nxt_flag;
			cnt_ff <= nxt_cnt;
		end
	end

	assign cfg.magnitude = mag_ff;
	assign cfg.flag = flag_ff;
endmodule

// ==== link_rx_model.sv ====
// Purpose: Far side of the sample link, recovers sample and overrange bit
// Assumes: Sample in the upper 14 bits, control bits filled from the MSB down
// Notes: Pure decode, no latency of its own
module link_rx_model (
	input wire logic [15:0] sample_out, // Word arriving on the link
	output logic [13:0] rx_sample, // Recovered converter sample
	output logic rx_ovr // Most significant control bit
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------------------------------------
	// Field split
	// --------------------------------------------------------------
	assign rx_sample = sample_out[15:2];
	// One control bit in use still lands in the top control position
	assign rx_ovr = sample_out[1];
endmodule

// ==== overrange_fast_detect.sv ====
// Purpose: Overrange flagging, sticky status and fast detect output
// Assumes: Register port carries decoded serial control port accesses
// Notes: Output word holds the sample in its upper bits, control bits below
// Functional notes
// - Raise overrange indicator when converter input exceeds its range.
// - With control bits enabled, carry overrange as sample control bit.
// - Overrange indicator latency equals the sample data latency.
// - Eight sticky overrange bits, one per virtual converter, held.
// - Clear sticky bit by writing clear bit one then zero.
// - Set fast detect at once when magnitude exceeds upper threshold.
// - Clear fast detect after magnitude below lower for over dwell.
// - Upper threshold over two addresses, compared with output magnitude.
// - Fast detect asserts within 28 clocks of upper crossing.
// - Lower threshold is 13 bits over two addresses, full scale 2^13.
// - Dwell time 1 to 65535 clocks over two addresses.
// - Three-bit field selects what drives the fast detect pin.
module overrange_fast_detect #(
	parameter int DATA_LATENCY = overrange_pkg::DATA_LATENCY
) (
	input wire logic clock, // Sample clock, 125 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [13:0] sample_in, // Converter output sample
	input wire logic overrange_in, // Converter input out of range
	input wire logic [7:0] vc_overrange, // Overrange per virtual converter
	input wire logic alt_pin_source, // Alternative source for the pin
	input wire logic [1:0] control_bits_per_sample, // Control bits used
	input wire logic [11:0] reg_addr, // Register address
	input wire logic reg_wr_en, // Register write strobe
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] reg_rd_data, // Register read data
	output logic [15:0] sample_out, // Sample with control bits
	output logic fast_detect_flag, // Threshold flag
	output logic fd_pin // Fast detect pin function
);
	initial begin
		if (DATA_LATENCY < 2)
			$error("DATA_LATENCY must be at least 2");
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [2:0] pin_sel_ff;
	logic [7:0] upper_lo_ff;
	logic [4:0] upper_hi_ff;
	logic [7:0] lower_lo_ff;
	logic [4:0] lower_hi_ff;
	logic [7:0] dwell_lo_ff;
	logic [7:0] dwell_hi_ff;
	logic [7:0] clear_ff;
	logic [7:0] sticky_ff;
	logic [7:0] nxt_sticky;
	logic [7:0] rd_mux;

	wire hit_pin_sel = reg_addr == overrange_pkg::FD_PIN_SEL_OFS;
	wire hit_upper_lo = reg_addr == overrange_pkg::UPPER_LO_OFS;
	wire hit_upper_hi = reg_addr == overrange_pkg::UPPER_HI_OFS;
	wire hit_lower_lo = reg_addr == overrange_pkg::LOWER_LO_OFS;
	wire hit_lower_hi = reg_addr == overrange_pkg::LOWER_HI_OFS;
	wire hit_dwell_lo = reg_addr == overrange_pkg::DWELL_LO_OFS;
	wire hit_dwell_hi = reg_addr == overrange_pkg::DWELL_HI_OFS;
	wire hit_clear = reg_addr == overrange_pkg::OVR_CLEAR_OFS;
	wire hit_sticky = reg_addr == overrange_pkg::OVR_STICKY_OFS;

	always_ff @(posedge clock) begin
		if (srst) begin
			pin_sel_ff <= overrange_pkg::PIN_SEL_RST;
			upper_lo_ff <= overrange_pkg::THR_LO_RST;
			upper_hi_ff <= overrange_pkg::THR_HI_RST;
			lower_lo_ff <= overrange_pkg::THR_LO_RST;
			lower_hi_ff <= overrange_pkg::THR_HI_RST;
			dwell_lo_ff <= overrange_pkg::DWELL_LO_RST;
			dwell_hi_ff <= overrange_pkg::DWELL_HI_RST;
			clear_ff <= overrange_pkg::CLEAR_RST;
		end else if (reg_wr_en) begin
			if (hit_pin_sel)
				pin_sel_ff <= reg_wdata[2:0];
			if (hit_upper_lo)
				upper_lo_ff <= reg_wdata;
			if (hit_upper_hi)
				upper_hi_ff <= reg_wdata[4:0];
			if (hit_lower_lo)
				lower_lo_ff <= reg_wdata;
			if (hit_lower_hi)
				lower_hi_ff <= reg_wdata[4:0];
			if (hit_dwell_lo)
				dwell_lo_ff <= reg_wdata;
			if (hit_dwell_hi)
				dwell_hi_ff <= reg_wdata;
			if (hit_clear)
				clear_ff <= reg_wdata;
		end
	end

	// Unmapped and reserved bits read as zero
	assign rd_mux = hit_pin_sel ? {5'h00, pin_sel_ff} :
		hit_upper_lo ? upper_lo_ff :
		hit_upper_hi ? {3'h0, upper_hi_ff} :
		hit_lower_lo ? lower_lo_ff :
		hit_lower_hi ? {3'h0, lower_hi_ff} :
		hit_dwell_lo ? dwell_lo_ff :
		hit_dwell_hi ? dwell_hi_ff :
		hit_clear ? clear_ff :
		hit_sticky ? sticky_ff : 8'h00;

	always_ff @(posedge clock) begin
		if (srst)
			reg_rd_data <= 8'h00;
		else
			reg_rd_data <= rd_mux;
	end

	// ----------------------------------------------------------------
	// Sticky overrange status
	// ----------------------------------------------------------------
	// Clear holds while the clear bit is high; a new event still wins
	assign nxt_sticky = vc_overrange | (sticky_ff & ~clear_ff);

	always_ff @(posedge clock) begin
		if (srst)
			sticky_ff <= 8'h00;
		else
			sticky_ff <= nxt_sticky;
	end

	// ----------------------------------------------------------------
	// Sample path with overrange control bit
	// ----------------------------------------------------------------
	logic [14:0] delayed_w;
	logic [1:0] ctrl_w;
	logic [15:0] nxt_sample_out;

	// Overrange rides the same pipe as its sample
	sample_delay #(
		.W(15),
		.DEPTH(DATA_LATENCY - 1)
	) u_delay (
		.clock(clock),
		.srst(srst),
		.din({sample_in, overrange_in}),
		.dout(delayed_w)
	);

	// Control bits fill from the most significant one downward
	assign ctrl_w = (control_bits_per_sample != 2'h0) ? {delayed_w[0], 1'b0} : 2'h0;
	assign nxt_sample_out = {delayed_w[14:1], ctrl_w};

	always_ff @(posedge clock) begin
		if (srst)
			sample_out <= 16'h0000;
		else
			sample_out <= nxt_sample_out;
	end

	// ----------------------------------------------------------------
	// Fast detect
	// ----------------------------------------------------------------
	fd_cfg_if fd ();

	assign fd.upper = {upper_hi_ff, upper_lo_ff};
	assign fd.lower = {lower_hi_ff, lower_lo_ff};
	assign fd.dwell = {dwell_hi_ff, dwell_lo_ff};

	fd_hysteresis u_fd (
		.clock(clock),
		.srst(srst),
		.sample_in(sample_in),
		.cfg(fd)
	);

	assign fast_detect_flag = fd.flag;

	logic nxt_fd_pin;
	// Unused selections hold the pin low
	assign nxt_fd_pin = (pin_sel_ff == overrange_pkg::PIN_SEL_FLAG) ? fd.flag :
		(pin_sel_ff == overrange_pkg::PIN_SEL_ALT) ? alt_pin_source : 1'b0;

	always_ff @(posedge clock) begin
		if (srst)
			fd_pin <= 1'b0;
		else
			fd_pin <= nxt_fd_pin;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// Run of samples below lower while the flag is up
	logic [16:0] below_run_ff;
	always_ff @(posedge clock) begin
		if (srst)
			below_run_ff <= '0;
		else if (fd.flag && fd.magnitude < fd.lower && fd.magnitude <= fd.upper)
			below_run_ff <= 17'(below_run_ff + 17'h00001);
		else
			below_run_ff <= '0;
	end

	sequence s_over;
		fd.magnitude > fd.upper;
	endsequence

	sequence s_between;
		fd.magnitude >= fd.lower && fd.magnitude <= fd.upper;
	endsequence

	ovr_ctrl_bit_a: assert property (
		control_bits_per_sample != 2'h0 |->
		sample_out[1] == $past(overrange_in, DATA_LATENCY))
		else $error("overrange bit not aligned with sample");

	ctrl_off_a: assert property (
		$past(control_bits_per_sample) == 2'h0 |-> sample_out[1:0] == 2'h0)
		else $error("control bits present while disabled");

	data_latency_a: assert property (
		sample_out[15:2] == $past(sample_in, DATA_LATENCY))
		else $error("sample latency wrong");

	sticky_set_a: assert property (
		vc_overrange != 8'h00 |=> (sticky_ff & $past(vc_overrange)) == $past(vc_overrange))
		else $error("sticky bit missed an overrange");

	sticky_hold_a: assert property (
		vc_overrange == 8'h00 && clear_ff == 8'h00 |=> $stable(sticky_ff))
		else $error("sticky bits changed without cause");

	sticky_clear_a: assert property (
		reg_wr_en && hit_clear ##1 vc_overrange == 8'h00 |=>
		(sticky_ff & $past(clear_ff)) == 8'h00)
		else $error("sticky bit not cleared");

	fd_set_a: assert property (
		s_over |=> fd.flag ##0 fd.flag [*2])
		else $error("fast detect not set by upper crossing");

	fd_latency_a: assert property (
		(sample_in[13] ? 14'(~sample_in + 14'h0001) : sample_in) > {1'b0, fd.upper}
		|-> ##[1:2] fd.flag)
		else $error("fast detect later than allowed");

	fd_hold_a: assert property (
		s_between |=> $stable(fd.flag))
		else $error("flag moved between thresholds");

	fd_clear_a: assert property (
		$fell(fd.flag) |-> $past(fd.magnitude < fd.lower) &&
		$past(below_run_ff) >= {1'b0, $past(fd.dwell)})
		else $error("flag cleared before dwell");

	pin_sel_a: assert property (
		pin_sel_ff == overrange_pkg::PIN_SEL_ALT |=> fd_pin == $past(alt_pin_source))
		else $error("pin does not follow selected source");

	split_reg_a: assert property (
		reg_wr_en && hit_upper_lo |=> fd.upper[7:0] == $past(reg_wdata))
		else $error("low byte not at lower address");
endmodule

// ==== overrange_pkg.sv ====
// Purpose: Shared constants for the overrange and fast detect block
// Assumes: One sample clock, 8-bit register port with 12-bit addresses
// Notes: Reset values are zero except DWELL_LO_RST, which is one
package overrange_pkg;
	// --------------------------------------------------------------
	// Widths and latencies
	// --------------------------------------------------------------
	localparam int SAMPLE_W = 14;
	localparam int MAG_W = 13;
	localparam int DWELL_W = 16;
	localparam int NUM_VC = 8;
	localparam int CTRL_W = 2;
	localparam int ADDR_W = 12;
	localparam int DATA_LATENCY = 4;
	localparam int FD_MAX_LATENCY = 28;
	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [11:0] FD_PIN_SEL_OFS = 12'h040;
	localparam logic [11:0] UPPER_LO_OFS = 12'h247;
	localparam logic [11:0] UPPER_HI_OFS = 12'h248;
	localparam logic [11:0] LOWER_LO_OFS = 12'h249;
	localparam logic [11:0] LOWER_HI_OFS = 12'h24A;
	localparam logic [11:0] DWELL_LO_OFS = 12'h24B;
	localparam logic [11:0] DWELL_HI_OFS = 12'h24C;
	localparam logic [11:0] OVR_CLEAR_OFS = 12'h562;
	localparam logic [11:0] OVR_STICKY_OFS = 12'h563;
	// --------------------------------------------------------------
	// Fields and reset values
	// --------------------------------------------------------------
	localparam int PIN_SEL_W = 3;
	localparam int THR_HI_W = 5;
	localparam logic [2:0] PIN_SEL_FLAG = 3'h0;
	localparam logic [2:0] PIN_SEL_ALT = 3'h1;
	localparam logic [2:0] PIN_SEL_RST = 3'h0;
	localparam logic [7:0] THR_LO_RST = 8'h00;
	localparam logic [4:0] THR_HI_RST = 5'h00;
	localparam logic [7:0] DWELL_LO_RST = 8'h01;
	localparam logic [7:0] DWELL_HI_RST = 8'h00;
	localparam logic [7:0] CLEAR_RST = 8'h00;
	localparam logic [12:0] MAG_SAT = 13'h1FFF;
	localparam logic [15:0] DWELL_SAT = 16'hFFFF;
endpackage

// ==== sample_delay.sv ====
// Purpose: Fixed-length register pipeline
// Assumes: DEPTH of at least one
// Notes: Used to keep the overrange bit in step with its sample
module sample_delay #(
	parameter int W = 15,
	parameter int DEPTH = 3
) (
	input wire logic clock, // Sample clock
	input wire logic srst, // Synchronous reset
	input wire logic [W-1:0] din, // Word entering the pipe
	output logic [W-1:0] dout // Word after DEPTH cycles
);
	logic [W-1:0] stage_ff [DEPTH];

	initial begin
		if (DEPTH < 1)
			$error("sample_delay needs DEPTH >= 1");
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++)
				stage_ff[i] <= '0;
		end else begin
			stage_ff[0] <= din;
			for (int i = 1; i < DEPTH; i++)
				stage_ff[i] <= stage_ff[i-1];
		end
	end

	assign dout = stage_ff[DEPTH-1];
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the overrange and fast detect block
// Assumes: Inputs change 1 ns after the rising edge, outputs read at 2 ns
// Notes: Drivers queue expected values, one monitor compares them on time
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int due; logic [15:0] v; string nm;} note_t;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [13:0] sample_in = 14'h0000;
	logic overrange_in = 1'b0;
	logic [7:0] vc_overrange = 8'h00;
	logic alt_pin_source = 1'b0;
	logic [1:0] control_bits_per_sample = 2'h0;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr_en = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rd_data;
	logic [15:0] sample_out;
	logic fast_detect_flag;
	logic fd_pin;
	logic [13:0] rx_sample;
	logic rx_ovr;
	int cyc = 0;
	int fails = 0;
	int checks_done = 0;
	note_t rq[$];
	note_t sq[$];
	note_t fq[$];
	note_t pq[$];
	bit chk_s = 1'b0;
	bit chk_f = 1'b0;
	bit rf = 1'b0;
	int rc = 0;
	int up = 0;
	int lo = 0;
	int dw = 1;
	logic [11:0] ra [10] = '{12'h040, 12'h247, 12'h248, 12'h249, 12'h24A, 12'h24B, 12'h24C,
		12'h562, 12'h563, 12'h123};
	logic [7:0] r0 [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] rw [10] = '{8'h07, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
	logic [1:0] cs [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
	int seq [24] = '{-1001, 700, 400, 400, 400, 400, 400, 500, 400, 400, 400, 400, 400, 400,
		1000, -8192, 499, 499, 499, 499, 499, 499, 0, 0};
	overrange_fast_detect dut (
		.clock(clock),
		.srst(srst),
		.sample_in(sample_in),
		.overrange_in(overrange_in),
		.vc_overrange(vc_overrange),
		.alt_pin_source(alt_pin_source),
		.control_bits_per_sample(control_bits_per_sample),
		.reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata),
		.reg_rd_data(reg_rd_data),
		.sample_out(sample_out),
		.fast_detect_flag(fast_detect_flag),
		.fd_pin(fd_pin)
	);
	link_rx_model partner (
		.sample_out(sample_out),
		.rx_sample(rx_sample),
		.rx_ovr(rx_ovr)
	);
	always #4 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	// --------------------------------------------------------------
	// Compare and report
	// --------------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic drain(ref note_t q[$], input logic [15:0] seen);
		note_t n;
		if (q.size() != 0 && q[0].due == cyc) begin
			n = q.pop_front();
			check(n.nm, seen, n.v);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		#2;
		drain(rq, {8'h00, reg_rd_data});
		drain(sq, {rx_sample, rx_ovr, sample_out[0]});
		drain(fq, {15'h0000, fast_detect_flag});
		drain(pq, {15'h0000, fd_pin});
	end
	// --------------------------------------------------------------
	// Drivers
	// --------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge clock) #1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		reg_wr_en = 1'b0;
		reg_addr = a;
		rq.push_back('{cyc + 1, {8'h00, e}, "reg_rd_data"});
		@(posedge clock) #1;
	endtask
	task automatic smp(input logic [13:0] s, input logic o);
		int m;
		m = $signed(s);
		if (m < 0) m = -m;
		if (m > 8191) m = 8191;
		reg_wr_en = 1'b0;
		sample_in = s;
		overrange_in = o;
		if (chk_s) sq.push_back('{cyc + overrange_pkg::DATA_LATENCY,
			{s, o && (control_bits_per_sample != 2'h0), 1'b0}, "sample_out"});
		// Reference hysteresis: dwell+1 samples strictly below lower clear it
		if (m > up) begin
			rf = 1'b1;
			rc = 0;
		end else if (rf && m < lo) begin
			if (rc >= dw) rf = 1'b0;
			else rc++;
		end else if (rf) begin
			rc = 0;
		end
		if (chk_f) begin
			fq.push_back('{cyc + 2, {15'h0000, rf}, "fast_detect_flag"});
			pq.push_back('{cyc + 3, {15'h0000, rf}, "fd_pin"});
		end
		@(posedge clock) #1;
	endtask
	task automatic pin(input logic a, input logic [2:0] sel, input bit note);
		reg_wr_en = 1'b0;
		alt_pin_source = a;
		if (note) pq.push_back('{cyc + 1, {15'h0000, (sel == 3'h1) ? a : 1'b0}, "fd_pin"});
		@(posedge clock) #1;
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		void'($urandom(8161));
		repeat (16) @(posedge clock);
		#1;
		srst = 1'b0;
		for (int i = 0; i < 10; i++) rd(ra[i], r0[i]);
		for (int i = 0; i < 10; i++) wr(ra[i], 8'hFF);
		for (int i = 0; i < 10; i++) rd(ra[i], rw[i]);
		for (int k = 0; k < 4; k++) begin
			chk_s = 1'b0;
			repeat (5) smp(14'h0000, 1'b0);
			control_bits_per_sample = cs[k];
			chk_s = 1'b1;
			repeat (20) smp(14'($urandom), 1'($urandom));
		end
		chk_s = 1'b0;
		wr(12'h247, 8'hE8);
		wr(12'h248, 8'h03);
		wr(12'h249, 8'hF4);
		wr(12'h24A, 8'h01);
		wr(12'h24B, 8'h05);
		wr(12'h24C, 8'h00);
		wr(12'h040, 8'h00);
		up = 1000;
		lo = 500;
		dw = 5;
		repeat (10) smp(14'h0000, 1'b0);
		rf = 1'b0;
		rc = 0;
		chk_f = 1'b1;
		foreach (seq[i]) smp(14'(seq[i]), 1'b0);
		repeat (80) smp(14'(int'($urandom_range(2200)) - 1100), 1'b0);
		chk_f = 1'b0;
		repeat (3) smp(14'h0000, 1'b0);
		for (int k = 1; k < 8; k++) begin
			wr(12'h040, 8'(k));
			repeat (2) pin(1'($urandom), 3'(k), 1'b0);
			repeat (8) pin(1'($urandom), 3'(k), 1'b1);
		end
		wr(12'h562, 8'h00);
		reg_wr_en = 1'b0;
		vc_overrange = 8'hA5;
		@(posedge clock) #1;
		vc_overrange = 8'h00;
		repeat (5) rd(12'h563, 8'hA5);
		wr(12'h562, 8'h05);
		wr(12'h562, 8'h00);
		rd(12'h563, 8'hA0);
		rd(12'h562, 8'h00);
		repeat (6) @(posedge clock);
		conclude();
	end
	// Guard against a hung sequence
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		conclude();
	end
endmodule
